// >>> core/fdq_trap_unit.sv
`timescale 1ns/1ns
`default_nettype none
module fdq_trap_unit
  import fdq_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter logic [2:0] FPU_VERSION = 3'h1 // Arbitrary value, not seven
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire fdq_kind_t issue_kind,
  input wire logic issue_unimpl,
  input wire logic [31:0] issue_addr,
  input wire logic [31:0] issue_word,
  input wire logic [31:0] issue_data,
  input wire logic op_done,
  input wire logic op_fault,
  input wire logic load_access_fault,
  output logic fp_trap,
  output logic [31:0] fp_status_word,
  output logic sfq_valid,
  output logic [31:0] sfq_addr0,
  output logic [31:0] sfq_data0,
  output logic [31:0] sfq_addr1,
  output logic [31:0] sfq_data1,
  output logic fill_valid,
  output logic [31:0] fill_data
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  fdq_qif #(.DEPTH(DEPTH)) q ();
  fdq_queue #(.DEPTH(DEPTH)) u_queue (.aclk(aclk), .aresetn(aresetn), .q(q));

  fdq_state_t state_q;
  fdq_state_t state_d;
  localparam int QCW = $clog2(DEPTH + 1);
  logic [31:0] stat_q;
  logic [2:0] ftt_q;
  logic [2:0] ftt_d;
  logic trap_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic sfq_valid_q;
  logic [31:0] sfq_addr0_q;
  logic [31:0] sfq_data0_q;
  logic [31:0] sfq_addr1_q;
  logic [31:0] sfq_data1_q;
  logic fill_valid_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  function automatic logic known(input logic [ADDR_W-1:0] a);
    known = (a == STAT_OFS) || (a == QSTAT_OFS) || (a == QADDR_OFS) ||
      (a == QWORD_OFS) || (a == CTRL_OFS);
  endfunction : known

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire take = issue_valid && issue_ready;
  wire is_run = (state_q == fp_running_state);
  wire is_pend = (state_q == fp_trap_pending_state);
  wire is_trap = (state_q == fp_trap_state);
  wire k_op = (issue_kind == KIND_OP);
  wire k_seq = k_op || (issue_kind == KIND_LOAD) || (issue_kind == KIND_BRANCH);
  wire k_sfq = (issue_kind == KIND_SFQ);
  wire k_lfsr = (issue_kind == KIND_LFSR);
  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire sw_flush = wr_go && (awaddr_q == CTRL_OFS) && wstrb_q[0] &&
    wdata_q[CTRL_FLUSH_POS];
  wire sw_stat = wr_go && (awaddr_q == STAT_OFS);
  wire run_push = take && is_run && k_op;
  wire run_fault = is_run && (op_fault || (run_push && issue_unimpl));
  wire trap_go = take && is_pend;
  wire seq_err = take && is_trap && k_seq;
  wire sfq_go = take && is_trap && k_sfq && q.not_empty;
  wire last_pop = sfq_go && (q.count == QCW'(1));
  wire lfsr_go = take && is_run && k_lfsr;

  // Back-pressure only when a new operation has no slot left
  assign issue_ready = !(is_run && k_op && q.full && !(op_done && q.not_empty));

  // Frozen once a fault is seen, so the faulting operation stays in front
  assign q.push = run_push && !sw_flush;
  assign q.push_addr = issue_addr;
  assign q.push_word = issue_word;
  assign q.pop = (is_run && op_done && !op_fault) || sfq_go;
  assign q.clear = sw_flush;

  always_comb begin
    state_d = state_q;
    ftt_d = ftt_q;
    unique case (state_q)
      fp_running_state: begin
        if (run_fault) begin
          state_d = fp_trap_pending_state;
        end
        if (run_push && issue_unimpl) begin
          ftt_d = FTT_UNIMP;
        end
      end
      fp_trap_pending_state: begin
        if (trap_go) begin
          state_d = fp_trap_state;
        end
      end
      fp_trap_state: begin
        if (seq_err) begin
          state_d = fp_trap_pending_state;
          ftt_d = FTT_SEQ;
        end else if (last_pop) begin
          state_d = fp_running_state;
        end
      end
      default: begin
        state_d = fp_running_state;
      end
    endcase
    if (sw_flush) begin
      state_d = fp_running_state;
      ftt_d = FTT_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and status word
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= fp_running_state;
      ftt_q <= FTT_NONE;
      trap_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ftt_q <= ftt_d;
      trap_q <= trap_go && !sw_flush;
    end
  end

  // Integer-side load wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= STAT_RESET;
    end else if (lfsr_go) begin
      stat_q <= issue_data & STAT_WMASK;
    end else if (sw_stat) begin
      stat_q <= merge(stat_q, wdata_q, wstrb_q) & STAT_WMASK;
    end
  end

  wire [31:0] stat_view = stat_q | (32'(FPU_VERSION) << VER_LSB) |
    (32'(ftt_q) << FTT_LSB) | (32'(q.not_empty) << QNE_POS);
  assign fp_status_word = stat_view;
  assign fp_trap = trap_q;

  // ---------------------------------------------------------------
  // Store-front and load-fault outputs
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sfq_valid_q <= 1'b0;
      sfq_addr0_q <= '0;
      sfq_data0_q <= '0;
      sfq_addr1_q <= '0;
      sfq_data1_q <= '0;
      fill_valid_q <= 1'b0;
    end else begin
      sfq_valid_q <= sfq_go && !sw_flush;
      if (sfq_go) begin
        sfq_addr0_q <= issue_data;
        sfq_data0_q <= q.front_addr;
        sfq_addr1_q <= issue_data + ADDR_STEP;
        sfq_data1_q <= q.front_word;
      end
      fill_valid_q <= load_access_fault;
    end
  end

  assign sfq_valid = sfq_valid_q;
  assign sfq_addr0 = sfq_addr0_q;
  assign sfq_data0 = sfq_data0_q;
  assign sfq_addr1 = sfq_addr1_q;
  assign sfq_data1 = sfq_data1_q;
  assign fill_valid = fill_valid_q;
  assign fill_data = ALL_ONES;

  // ---------------------------------------------------------------
  // Register slave
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  wire [31:0] rd_mux =
    (s_axi_araddr == STAT_OFS) ? stat_view :
    (s_axi_araddr == QSTAT_OFS) ? (32'(q.count) | (32'(state_q) << QST_STATE_LSB)) :
    (s_axi_araddr == QADDR_OFS) ? q.front_addr :
    (s_axi_araddr == QWORD_OFS) ? q.front_word : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence pend_issue;
    is_pend && issue_valid && issue_ready && !sw_flush;
  endsequence
  sequence trap_entry;
    is_trap && fp_trap;
  endsequence
  sequence seq_cause;
    is_trap && issue_valid && issue_ready && k_seq && !sw_flush;
  endsequence

  ver_fixed_a: assert property (
    fp_status_word[VER_LSB +: VER_W] == FPU_VERSION &&
    FPU_VERSION != NO_FPU_VER) else $error("version field wrong");
  load_keeps_ver_a: assert property (lfsr_go |=>
    $stable(fp_status_word[VER_LSB +: VER_W])) else $error("load moved version");
  run_to_pend_a: assert property (is_run && op_fault && !sw_flush |=>
    is_pend) else $error("fault did not pend");
  pend_trap_a: assert property (pend_issue |=> trap_entry)
    else $error("pending issue did not trap");
  trap_only_entry_a: assert property (fp_trap |->
    $past(is_pend) && is_trap) else $error("trap outside entry");
  seq_err_a: assert property (seq_cause |-> !q.push ##1
    (is_pend && ftt_q == FTT_SEQ && !fp_trap)) else $error("sequence error wrong");
  front_store_a: assert property (sfq_go && !sw_flush |=>
    sfq_valid && sfq_addr1 == sfq_addr0 + ADDR_STEP &&
    sfq_data0 == $past(q.front_addr)) else $error("front store wrong");
  drain_done_a: assert property (last_pop && !seq_err && !sw_flush |=>
    is_run && !fp_status_word[QNE_POS]) else $error("drain did not end trap");
  fill_ones_a: assert property (load_access_fault |=>
    fill_valid && fill_data == ALL_ONES) else $error("fill not all ones");
endmodule : fdq_trap_unit
`default_nettype wire

// >>> core/fdq_pkg.sv
`default_nettype none
package fdq_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] STAT_OFS = 8'h00;
  localparam logic [7:0] QSTAT_OFS = 8'h04;
  localparam logic [7:0] QADDR_OFS = 8'h08;
  localparam logic [7:0] QWORD_OFS = 8'h0C;
  localparam logic [7:0] CTRL_OFS = 8'h10;
  localparam int ADDR_W = 8;

  // ---------------------------------------------------------------
  // Status word layout
  // ---------------------------------------------------------------
  localparam int VER_LSB = 17;
  localparam int VER_W = 3;
  localparam int FTT_LSB = 14;
  localparam int FTT_W = 3;
  localparam int QNE_POS = 13;
  localparam logic [31:0] STAT_WMASK = 32'hFFF0_1FFF;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  localparam logic [2:0] NO_FPU_VER = 3'h7;
  localparam logic [2:0] FTT_NONE = 3'h0;
  localparam logic [2:0] FTT_UNIMP = 3'h3;
  localparam logic [2:0] FTT_SEQ = 3'h4;
  localparam int CTRL_FLUSH_POS = 0;
  localparam int QST_STATE_LSB = 8;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

  // ---------------------------------------------------------------
  // Bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    fp_running_state = 2'b00,
    fp_trap_pending_state = 2'b01,
    fp_trap_state = 2'b10
  } fdq_state_t;

  typedef enum logic [2:0] {
    KIND_OP = 3'b000,
    KIND_LOAD = 3'b001,
    KIND_BRANCH = 3'b010,
    KIND_STORE = 3'b011,
    KIND_SFQ = 3'b100,
    KIND_SFSR = 3'b101,
    KIND_LFSR = 3'b110
  } fdq_kind_t;

endpackage : fdq_pkg
`default_nettype wire

// >>> core/fdq_qif.sv
`timescale 1ns/1ns
`default_nettype none
interface fdq_qif #(parameter int DEPTH = 4);
  localparam int CW = $clog2(DEPTH + 1);
  logic push;
  logic pop;
  logic clear;
  logic [31:0] push_addr;
  logic [31:0] push_word;
  logic [31:0] front_addr;
  logic [31:0] front_word;
  logic [CW-1:0] count;
  logic full;
  logic not_empty;
  modport ctl (output push, pop, clear, push_addr, push_word,
    input front_addr, front_word, count, full, not_empty);
  modport store (input push, pop, clear, push_addr, push_word,
    output front_addr, front_word, count, full, not_empty);
endinterface : fdq_qif
`default_nettype wire

// >>> core/fdq_queue.sv
`timescale 1ns/1ns
`default_nettype none
module fdq_queue #(
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  fdq_qif.store q
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // ---------------------------------------------------------------
  // Doubleword storage
  // ---------------------------------------------------------------
  logic [31:0] addr_mem [DEPTH];
  logic [31:0] word_mem [DEPTH];
  logic [PW-1:0] rd_q;
  logic [PW-1:0] wr_q;
  logic [CW-1:0] cnt_q;
  logic push_ok;
  logic pop_ok;

  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : step

  assign pop_ok = q.pop && (cnt_q != '0);
  // Push into a full queue is allowed only when a pop frees a slot
  assign push_ok = q.push && ((cnt_q != CW'(DEPTH)) || pop_ok);
  assign q.front_addr = addr_mem[rd_q];
  assign q.front_word = word_mem[rd_q];
  assign q.count = cnt_q;
  assign q.full = (cnt_q == CW'(DEPTH));
  assign q.not_empty = (cnt_q != '0);

  always_ff @(posedge aclk) begin
    if (push_ok) begin
      addr_mem[wr_q] <= q.push_addr;
      word_mem[wr_q] <= q.push_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || q.clear) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push_ok) begin
        wr_q <= step(wr_q);
      end
      if (pop_ok) begin
        rd_q <= step(rd_q);
      end
      cnt_q <= cnt_q + CW'(push_ok) - CW'(pop_ok);
    end
  end

  count_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_q <= CW'(DEPTH)) else $error("queue count above depth");
endmodule : fdq_queue
`default_nettype wire

// >>> sim/fdq_iu_model.sv
`timescale 1ns/1ns
`default_nettype none
module fdq_int_unit_model
  import fdq_pkg::*;
(
  input wire logic aclk,
  input wire logic issue_ready,
  output logic issue_valid,
  output var fdq_kind_t issue_kind,
  output logic issue_unimpl,
  output logic [31:0] issue_addr,
  output logic [31:0] issue_word,
  output logic [31:0] issue_data
);
  // ---------------------------------------------------------------
  // Issue side
  // ---------------------------------------------------------------
  initial begin
    issue_valid = 1'b0;
    issue_kind = KIND_OP;
    issue_unimpl = 1'b0;
    issue_addr = 32'h0;
    issue_word = 32'h0;
    issue_data = 32'h0;
  end

  // Held until taken; address, word and data inverted after release so stale data cannot pass
  task automatic issue(input fdq_kind_t k, input logic u, input logic [31:0] a,
      input logic [31:0] w, input logic [31:0] d);
    @(posedge aclk);
    issue_valid <= 1'b1;
    issue_kind <= k;
    issue_unimpl <= u;
    issue_addr <= a;
    issue_word <= w;
    issue_data <= d;
    do @(posedge aclk); while (issue_ready !== 1'b1);
    issue_valid <= 1'b0;
    issue_addr <= ~a;
    issue_word <= ~w;
    issue_data <= ~d;
  endtask : issue
endmodule : fdq_int_unit_model
`default_nettype wire

// >>> sim/fp_deferred_trap_queue_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module fp_deferred_trap_queue_tb_top
  import fdq_pkg::*;
;
  localparam logic [2:0] VER = 3'h2; // Arbitrary version code
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, issue_valid, issue_ready, issue_unimpl, op_done, op_fault;
  logic load_access_fault, fp_trap, sfq_valid, fill_valid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_wdata, s_axi_rdata, issue_addr, issue_word, issue_data, fp_status_word;
  logic [31:0] sfq_addr0, sfq_data0, sfq_addr1, sfq_data1, fill_data, rd, ea, fill_seen;
  logic [31:0] sa0, sd0, sa1, sd1;
  logic [31:0] qa [4];
  logic [31:0] qw [4];
  fdq_kind_t issue_kind;
  int n_fail, compares, n_trap, n_fill, i;
  integer seed;

  fdq_trap_unit #(.DEPTH(4), .FPU_VERSION(VER)) u_fdq_trap_unit (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .issue_valid, .issue_ready, .issue_kind,
    .issue_unimpl, .issue_addr, .issue_word, .issue_data, .op_done, .op_fault,
    .load_access_fault, .fp_trap, .fp_status_word, .sfq_valid, .sfq_addr0,
    .sfq_data0, .sfq_addr1, .sfq_data1, .fill_valid, .fill_data);
  fdq_int_unit_model u_fdq_int_unit_model (.aclk, .issue_ready, .issue_valid, .issue_kind,
    .issue_unimpl, .issue_addr, .issue_word, .issue_data);

  // ---------------------------------------------------------------
  // Clock, monitor, watchdog
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Counting pulses at every edge also catches traps at unexpected times
  always @(posedge aclk) begin
    if (fp_trap === 1'b1) n_trap++;
    if (sfq_valid === 1'b1) begin
      sa0 = sfq_addr0;
      sd0 = sfq_data0;
      sa1 = sfq_addr1;
      sd1 = sfq_data1;
    end
    if (fill_valid === 1'b1) begin
      n_fill++;
      fill_seen = fill_data;
    end
  end
  initial begin
    #(20 * 5000);
    n_fail++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] fld(input logic [2:0] v, input logic [2:0] t, input logic q);
    return {v, t, q};
  endfunction : fld

  task automatic stop_test();
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~ad;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~ad;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic pulse(input int which);
    @(posedge aclk);
    if (which == 0) op_done <= 1'b1;
    if (which == 1) op_fault <= 1'b1;
    if (which == 2) load_access_fault <= 1'b1;
    @(posedge aclk);
    {op_done, op_fault, load_access_fault} <= 3'b000;
    repeat (2) @(posedge aclk);
  endtask : pulse

  task automatic iss(input fdq_kind_t k, input logic u, input logic [31:0] a,
      input logic [31:0] w, input logic [31:0] d);
    u_fdq_int_unit_model.issue(k, u, a, w, d);
    repeat (2) @(posedge aclk);
  endtask : iss

  // Queue status read; not-empty flag must follow the count
  task automatic chk_q(input logic [1:0] st, input logic [2:0] cnt);
    axi_rd(QSTAT_OFS, rd, rsp);
    `CHK(rd[9:8], st)
    `CHK(rd[2:0], cnt)
    `CHK(fp_status_word[QNE_POS], cnt != 3'h0)
  endtask : chk_q

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'he2b5;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
    {s_axi_rready, op_done, op_fault, load_access_fault} = 4'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    `CHK(fp_status_word[19:13], fld(VER, FTT_NONE, 1'b0))
    `CHK(fp_status_word[19:17] != NO_FPU_VER, 1'b1)
    axi_wr(STAT_OFS, 32'hFFFF_FFFF, rsp);
    axi_rd(STAT_OFS, rd, rsp);
    `CHK(rd[19:17], VER)
    `CHK(rsp, RESP_OKAY)
    iss(KIND_LFSR, 1'b0, 32'h0, 32'h0, ALL_ONES);
    `CHK(fp_status_word[19:17], VER)
    axi_wr(8'h20, $random(seed), rsp);
    `CHK(rsp, RESP_SLVERR)
    axi_rd(8'h24, rd, rsp);
    `CHK(rsp, RESP_SLVERR)
    axi_wr(STAT_OFS, 32'h0, rsp);
    for (i = 0; i < 4; i++) begin
      qa[i] = $random(seed) & 32'hFFFF_FFFC;
      qw[i] = $random(seed);
    end
    for (i = 0; i < 3; i++) iss(KIND_OP, 1'b0, qa[i], qw[i], 32'h0);
    chk_q(2'b00, 3'h3);
    pulse(0);
    chk_q(2'b00, 3'h2);
    pulse(1);
    chk_q(2'b01, 3'h2);
    `CHK(n_trap, 0)
    iss(KIND_BRANCH, 1'b0, 32'h0, 32'h0, 32'h0);
    `CHK(n_trap, 1)
    chk_q(2'b10, 3'h2);
    axi_rd(QADDR_OFS, rd, rsp);
    `CHK(rd, qa[1])
    axi_rd(QWORD_OFS, rd, rsp);
    `CHK(rd, qw[1])
    // Only operations, loads and branches are illegal while trapped; the rest trap only when issued while a trap is pending
    iss(KIND_SFSR, 1'b0, 32'h0, 32'h0, 32'h0);
    `CHK(n_trap, 1)
    for (i = 0; i < 3; i++) begin
      iss(fdq_kind_t'(i), 1'b0, qa[3], qw[3], 32'h0);
      `CHK(fp_status_word[16:14], FTT_SEQ)
      chk_q(2'b01, 3'h2);
      iss(KIND_STORE, 1'b0, 32'h0, 32'h0, 32'h0);
      `CHK(n_trap, 2 + i)
    end
    for (i = 1; i < 3; i++) begin
      ea = $random(seed) & 32'hFFFF_FFFC;
      iss(KIND_SFQ, 1'b0, 32'h0, 32'h0, ea);
      `CHK({sa0, sd0, sa1, sd1}, {ea, qa[i], ea + ADDR_STEP, qw[i]})
      chk_q(i == 1 ? 2'b10 : 2'b00, 3'(2 - i));
    end
    iss(KIND_OP, 1'b1, qa[3], qw[3], 32'h0);
    `CHK(fp_status_word[16:14], FTT_UNIMP)
    chk_q(2'b01, 3'h1);
    iss(KIND_LOAD, 1'b0, 32'h0, 32'h0, 32'h0);
    `CHK(n_trap, 5)
    iss(KIND_SFQ, 1'b0, 32'h0, 32'h0, 32'h0000_0100);
    `CHK({sa0, sd0, sa1, sd1}, {32'h0000_0100, qa[3], 32'h0000_0104, qw[3]})
    chk_q(2'b00, 3'h0);
    // Software flush from a pending fault must empty the queue and clear the type
    iss(KIND_OP, 1'b0, qa[0], qw[0], 32'h0);
    pulse(1);
    axi_wr(CTRL_OFS, 32'h0000_0001, rsp);
    `CHK(rsp, RESP_OKAY)
    `CHK(fp_status_word[16:14], FTT_NONE)
    chk_q(2'b00, 3'h0);
    pulse(2);
    `CHK(n_fill, 1)
    `CHK(fill_seen, ALL_ONES)
    stop_test();
  end
endmodule : fp_deferred_trap_queue_tb_top
`default_nettype wire
